// [logic/clock_output_power_control.v]
// power-good sequencing, strap capture, pair gating and reference pin control
// assumes pins arrive asynchronously and the synthesizer lock is a slow level
`timescale 1ns/1ps
`default_nettype none
`include "clock_output_power_control_regs.vh"
module clock_output_power_control #(
   parameter NUM_PAIRS   = 8,
   parameter STAB_CYCLES = `T_STAB_NS / `CLK_PERIOD_NS,
   parameter DRV_CYCLES  = `T_DRV_PD_NS / `CLK_PERIOD_NS
) (
   input  wire                 pclk,
   input  wire                 presetn,
   input  wire [7:0]           paddr,
   input  wire                 psel,
   input  wire                 penable,
   input  wire                 pwrite,
   input  wire [31:0]          pwdata,
   output reg  [31:0]          prdata,
   output reg                  pready,
   output reg                  pslverr,
   input  wire                 power_good_powerdown_n,
   input  wire [NUM_PAIRS-1:0] pair_output_enable_n,
   input  wire [1:0]           spread_strap_level,
   input  wire                 synth_lock,
   input  wire                 crystal_input,
   input  wire                 ref_pin_in,
   output reg                  ref_pin_out,
   output reg                  ref_pin_oe,
   output wire [NUM_PAIRS-1:0] diff_clock_pair_true,
   output wire [NUM_PAIRS-1:0] diff_clock_pair_comp,
   output reg  [6:0]           bus_address,
   output reg  [1:0]           spread_select
);
   localparam CW = 20;
   localparam [CW-1:0] STAB_LIMIT = STAB_CYCLES[CW-1:0];
   localparam [CW-1:0] DRV_LIMIT  = DRV_CYCLES[CW-1:0];
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_RUN  = 3'b010;
   localparam [2:0] ST_PD   = 3'b100;

   wire [NUM_PAIRS-1:0] oen_s;
   wire [1:0]           spread_s;
   wire                 pg_s;
   wire                 lock_s;
   wire                 xtal_s;
   wire                 ref_s;
   wire [NUM_PAIRS-1:0] run_w;

   reg  [2:0]           state_reg;
   reg  [2:0]           state_next;
   reg                  pg_d_reg;
   reg  [NUM_PAIRS-1:0] oe_bits_reg;
   reg                  wake_reg;
   reg                  addr_strap_reg;
   reg                  stab_late_reg;
   reg                  drv_late_reg;
   reg                  waiting_reg;
   reg                  from_pd_reg;
   reg  [CW-1:0]        wait_cnt_reg;
   reg                  phase_reg;

   // undriven enable pins read as enabled, so reset to 0
   sync2 #(.WIDTH(NUM_PAIRS), .INIT({NUM_PAIRS{1'b0}})) u_sync_oe (
      .clk   (pclk),
      .rst_n (presetn),
      .d     (pair_output_enable_n),
      .q     (oen_s)
   );
   sync2 #(.WIDTH(6), .INIT(6'h00)) u_sync_misc (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({spread_strap_level, power_good_powerdown_n, synth_lock, crystal_input,
               ref_pin_in}),
      .q     ({spread_s, pg_s, lock_s, xtal_s, ref_s})
   );

   wire pg_rise = pg_s & ~pg_d_reg;
   wire access  = psel & penable;
   wire wr_done = access & pwrite & pready;
   wire rd_now  = access & ~pwrite & ~pready;
   wire mapped  = (paddr == `OFS_CTRL) || (paddr == `OFS_STATUS) ||
                  (paddr == `OFS_BUS_ADDR) || (paddr == `OFS_PAIR_STATE);

   // power sequencing
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: if (pg_rise) state_next = ST_RUN;
         ST_RUN:  if (!pg_s)   state_next = ST_PD;
         ST_PD:   if (pg_s)    state_next = ST_RUN;
         default: state_next = ST_IDLE;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         pg_d_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         pg_d_reg  <= pg_s;
      end
   end

   // straps caught once, held until a full reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_strap_reg <= 1'b0;
         bus_address    <= `ADDR_STRAP_0;
         spread_select  <= `SPREAD_OFF;
      end else if (state_reg == ST_IDLE && pg_rise) begin
         addr_strap_reg <= ref_s;
         bus_address    <= ref_s ? `ADDR_STRAP_1 : `ADDR_STRAP_0;
         case (spread_s)
            2'b11:   spread_select <= `SPREAD_HALF;
            2'b01:   spread_select <= `SPREAD_QUARTER;
            default: spread_select <= `SPREAD_OFF;
         endcase
      end
   end

   // shared output phase, half of pclk
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         phase_reg <= 1'b0;
      else
         phase_reg <= ~phase_reg;
   end
   wire rise_now = ~phase_reg;
   wire fall_now = phase_reg;

   // pair enables; pins alone suffice since oe bits reset to all on
   genvar i;
   generate
      for (i = 0; i < NUM_PAIRS; i = i + 1) begin : g_pair
         pair_gate u_gate (
            .clk        (pclk),
            .rst_n      (presetn),
            .phase_next (~phase_reg),
            .rise_now   (rise_now),
            .fall_now   (fall_now),
            // power-good high, bit set, pin low, synthesizer locked
            .want_run   ((state_reg == ST_RUN) & pg_s & lock_s & oe_bits_reg[i] & ~oen_s[i]),
            .run_reg    (run_w[i]),
            .true_reg   (diff_clock_pair_true[i]),
            .comp_reg   (diff_clock_pair_comp[i])
         );
      end
   endgenerate

   // reference pin: floats before start, copy when live or with the wake option, low otherwise
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_pin_oe  <= 1'b0;
         ref_pin_out <= 1'b0;
      end else if (state_next == ST_IDLE) begin
         ref_pin_oe  <= 1'b0;
         ref_pin_out <= 1'b0;
      end else begin
         ref_pin_oe  <= 1'b1;
         // wake option keeps the copy alive in power-down
         ref_pin_out <= (state_next == ST_RUN || wake_reg) ? xtal_s : 1'b0;
      end
   end

   // start-up and wake deadline watch; late flags show a missing lock
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         waiting_reg   <= 1'b0;
         from_pd_reg   <= 1'b0;
         wait_cnt_reg  <= {CW{1'b0}};
         stab_late_reg <= 1'b0;
         drv_late_reg  <= 1'b0;
      end else begin
         if (state_reg != ST_RUN && state_next == ST_RUN) begin
            waiting_reg  <= 1'b1;
            from_pd_reg  <= (state_reg == ST_PD);
            wait_cnt_reg <= {CW{1'b0}};
         end else if (state_next != ST_RUN || lock_s) begin
            waiting_reg  <= 1'b0;
         end else if (waiting_reg) begin
            wait_cnt_reg <= wait_cnt_reg + 1'b1;
         end
         // set wins over a software clear
         if (waiting_reg && !lock_s && wait_cnt_reg == STAB_LIMIT)
            stab_late_reg <= 1'b1;
         else if (wr_done && paddr == `OFS_STATUS && pwdata[`ST_STAB_LATE_BIT])
            stab_late_reg <= 1'b0;
         if (waiting_reg && from_pd_reg && !lock_s && wait_cnt_reg == DRV_LIMIT)
            drv_late_reg <= 1'b1;
         else if (wr_done && paddr == `OFS_STATUS && pwdata[`ST_DRV_LATE_BIT])
            drv_late_reg <= 1'b0;
      end
   end

   // APB slave, one wait state so read data leaves a flip-flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready      <= 1'b0;
         pslverr     <= 1'b0;
         prdata      <= 32'h00000000;
         {wake_reg, oe_bits_reg} <= `CTRL_RESET;
      end else begin
         pready  <= access & ~pready;
         pslverr <= access & ~pready & ~mapped;
         if (rd_now) begin
            prdata <= 32'h00000000;
            case (paddr)
               `OFS_CTRL:       prdata[`CTRL_WAKE_BIT:0] <= {wake_reg, oe_bits_reg};
               `OFS_STATUS: begin
                  prdata[`ST_STARTED_BIT] <= (state_reg != ST_IDLE);
                  prdata[`ST_PDOWN_BIT]   <= (state_reg == ST_PD);
                  prdata[`ST_LOCK_BIT]    <= lock_s;
                  prdata[`ST_ADDR_BIT]    <= addr_strap_reg;
                  prdata[`ST_SPREAD_LSB+1:`ST_SPREAD_LSB] <= spread_select;
                  prdata[`ST_STAB_LATE_BIT] <= stab_late_reg;
                  prdata[`ST_DRV_LATE_BIT]  <= drv_late_reg;
               end
               `OFS_BUS_ADDR:   prdata[6:0] <= bus_address;
               `OFS_PAIR_STATE: prdata[NUM_PAIRS-1:0] <= run_w;
               default:         prdata <= 32'h00000000;
            endcase
         end
         if (wr_done && paddr == `OFS_CTRL) begin
            oe_bits_reg <= pwdata[`CTRL_OE_LSB+NUM_PAIRS-1:`CTRL_OE_LSB];
            wake_reg    <= pwdata[`CTRL_WAKE_BIT];
         end
      end
   end
endmodule
`default_nettype wire

// [logic/clock_output_power_control_regs.vh]
// constants for the clock output power control block
// assumes a 200 MHz pclk and an APB master with 32-bit data
`ifndef CLOCK_OUTPUT_POWER_CONTROL_REGS_VH
`define CLOCK_OUTPUT_POWER_CONTROL_REGS_VH

`define OFS_CTRL         8'h00
`define OFS_STATUS       8'h04
`define OFS_BUS_ADDR     8'h08
`define OFS_PAIR_STATE   8'h0C

`define CTRL_OE_LSB      0
`define CTRL_WAKE_BIT    8
`define CTRL_RESET       9'h0FF

`define ST_STARTED_BIT   0
`define ST_PDOWN_BIT     1
`define ST_LOCK_BIT      2
`define ST_ADDR_BIT      3
`define ST_SPREAD_LSB    4
`define ST_STAB_LATE_BIT 6
`define ST_DRV_LATE_BIT  7

`define ADDR_STRAP_0     7'h68
`define ADDR_STRAP_1     7'h6A

`define SPREAD_OFF       2'h0
`define SPREAD_QUARTER   2'h1
`define SPREAD_HALF      2'h3

`define CLK_PERIOD_NS    5
`define T_STAB_NS        1800000
`define T_DRV_PD_NS      300000

`endif

// [logic/sync2.v]
// two-flop synchroniser for a bus of independent levels
// assumes each bit is a slow level; no bus coherence is promised
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] d,
   output reg  [WIDTH-1:0] q
);
   reg [WIDTH-1:0] meta_reg;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= INIT;
         q        <= INIT;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// [logic/pair_gate.v]
// gating of one differential pair from the shared output phase
// assumes phase toggles every clock and fall_now marks the edge where it goes low
`timescale 1ns/1ps
`default_nettype none
module pair_gate (
   input  wire clk,
   input  wire rst_n,
   input  wire phase_next,
   input  wire rise_now,
   input  wire fall_now,
   input  wire want_run,
   output reg  run_reg,
   output reg  true_reg,
   output reg  comp_reg
);
   reg want_reg;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         want_reg <= 1'b0;
         run_reg  <= 1'b0;
         true_reg <= 1'b0;
         comp_reg <= 1'b0;
      end else begin
         // request taken on a rising phase, applied on the next fall: 2 to 3 clocks
         if (rise_now)
            want_reg <= want_run;
         if (fall_now)
            run_reg <= want_reg;
         // both legs low while stopped
         true_reg <= (fall_now ? want_reg : run_reg) & phase_next;
         comp_reg <= (fall_now ? want_reg : run_reg) & ~phase_next;
      end
   end
endmodule
`default_nettype wire

// [tb/clock_output_power_control_monitor.sv]
// concurrent checks on the top-level ports of the clock output block
// assumes a single pclk domain with presetn as asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module clock_output_power_control_monitor #(
   parameter NUM_PAIRS = 8
) (
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire logic                 power_good_powerdown_n,
   input wire logic [NUM_PAIRS-1:0] pair_output_enable_n,
   input wire logic                 synth_lock,
   input wire logic                 ref_pin_oe,
   input wire logic [NUM_PAIRS-1:0] diff_clock_pair_true,
   input wire logic [NUM_PAIRS-1:0] diff_clock_pair_comp,
   input wire logic [6:0]           bus_address,
   input wire logic [1:0]           spread_select
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   pair_legs_a: assert property ((diff_clock_pair_true & diff_clock_pair_comp) == '0)
      else $error("both legs of a pair high");
   pd_pairs_off_a: assert property (!power_good_powerdown_n [*8] |->
      diff_clock_pair_true == '0 && diff_clock_pair_comp == '0) else $error("pair runs in power-down");
   lock_block_a: assert property (!synth_lock [*8] |-> diff_clock_pair_true == '0)
      else $error("pair runs without lock");
   pin_off_a: assert property (pair_output_enable_n[0] [*8] |->
      !diff_clock_pair_true[0] && !diff_clock_pair_comp[0]) else $error("disabled pair runs");
   whole_pulse_a: assert property (diff_clock_pair_true[0] |=> !diff_clock_pair_true[0])
      else $error("pair pulse wider than one cycle");
   ref_start_a: assert property ($rose(ref_pin_oe) |-> power_good_powerdown_n
      && $past(power_good_powerdown_n, 2)) else $error("reference driven before power-good");
   ref_held_a: assert property (ref_pin_oe |=> ref_pin_oe)
      else $error("reference released after start");
   strap_hold_a: assert property ($past(ref_pin_oe, 2) |-> $stable(bus_address)
      && $stable(spread_select)) else $error("strap value changed after start");
   addr_code_a: assert property (bus_address == 7'h68 || bus_address == 7'h6A)
      else $error("illegal bus address");
   apb_wait_a: assert property (pready |-> penable && psel && $past(penable))
      else $error("ready without wait state");
   cover property (power_good_powerdown_n ##1 !power_good_powerdown_n);
   cover property ($rose(diff_clock_pair_true[7]));
   cover property (pready && pslverr);
endmodule
bind clock_output_power_control clock_output_power_control_monitor #(.NUM_PAIRS(NUM_PAIRS)) mon (
   .pclk, .presetn, .psel, .penable, .pready, .pslverr, .power_good_powerdown_n,
   .pair_output_enable_n, .synth_lock, .ref_pin_oe, .diff_clock_pair_true,
   .diff_clock_pair_comp, .bus_address, .spread_select);
`default_nettype wire

// [tb/system_controller.sv]
// system controller model driving power-good, pair enables and the crystal
// assumes requests from the bench; pins get pull levels when left undriven
`timescale 1ns/1ps
`default_nettype none
module system_controller (
   input  wire logic       pclk,
   input  wire logic       pg_want,
   input  wire logic [7:0] oe_want_n,
   output var  logic       power_good_powerdown_n,
   output var  logic [7:0] pair_output_enable_n,
   output var  logic       crystal_input
);
   logic [1:0] xtal_cnt;
   initial begin
      power_good_powerdown_n = 1'b0;
      pair_output_enable_n = 8'h00;
      crystal_input = 1'b0;
      xtal_cnt = 2'h0;
   end
   // undriven power-good floats high, undriven enables float low
   always @(posedge pclk) begin
      power_good_powerdown_n <= (pg_want !== 1'b0);
      for (int i = 0; i < 8; i++)
         pair_output_enable_n[i] <= (oe_want_n[i] === 1'b1);
      xtal_cnt <= xtal_cnt + 2'h1;
      if (xtal_cnt == 2'h3) crystal_input <= ~crystal_input; // 25 MHz
   end
endmodule
`default_nettype wire

// [tb/clock_output_power_control_bench.sv]
// self-checking bench for the clock output power control block
// assumes the system controller model on the pin side and an APB master here
`timescale 1ns/1ps
`default_nettype none
`include "clock_output_power_control_regs.vh"
module clock_output_power_control_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, synth_lock;
   logic        pg_want, strap_drive, ref_pin_out, ref_pin_oe, ref_pin_in, crystal_input;
   logic        power_good_powerdown_n;
   logic [7:0]  paddr, oe_want_n, pair_output_enable_n, diff_clock_pair_true, diff_clock_pair_comp;
   logic [31:0] pwdata, prdata, rd;
   logic [6:0]  bus_address;
   logic [1:0]  spread_strap_level, spread_select;
   logic        er;
   int          n_mismatch, compares, cycles;
   // shared pin: strap level until the block drives it
   assign ref_pin_in = ref_pin_oe ? ref_pin_out : strap_drive;
   clock_output_power_control #(.STAB_CYCLES(40), .DRV_CYCLES(20)) dut (.pclk, .presetn,
      .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .power_good_powerdown_n, .pair_output_enable_n, .spread_strap_level, .synth_lock,
      .crystal_input, .ref_pin_in, .ref_pin_out, .ref_pin_oe, .diff_clock_pair_true,
      .diff_clock_pair_comp, .bus_address, .spread_select);
   system_controller ctl (.pclk, .pg_want, .oe_want_n, .power_good_powerdown_n,
      .pair_output_enable_n, .crystal_input);
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task end_of_test;
      if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         end_of_test;
      end
   end
   // an edge passes first so back-to-back calls never assign psel twice in one step
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata; er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task pairs(input logic [7:0] exp);
      logic [7:0] a, ca, b;
      @(negedge pclk); a = diff_clock_pair_true; ca = diff_clock_pair_comp;
      @(negedge pclk); b = diff_clock_pair_true;
      chk(32'(a ^ b), 32'(exp));
      chk(32'(ca), 32'(~a & exp));
      @(posedge pclk);
   endtask
   task ref_moves(output logic t);
      logic s;
      t = 1'b0;
      @(negedge pclk); s = ref_pin_out;
      repeat (16) begin @(negedge pclk); if (ref_pin_out !== s) t = 1'b1; end
      @(posedge pclk);
   endtask
   task settle; repeat (12) @(posedge pclk); endtask
   task start_up(input logic strap, input logic [1:0] lvl, input logic [1:0] sp);
      logic t;
      presetn <= 1'b0; pg_want <= 1'b0; strap_drive <= strap; spread_strap_level <= lvl;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      settle;
      chk(32'(ref_pin_oe), 32'h0);
      pairs(8'h00);
      pg_want <= 1'b1;
      settle;
      chk(32'(bus_address), strap ? 32'(`ADDR_STRAP_1) : 32'(`ADDR_STRAP_0));
      chk(32'(spread_select), 32'(sp));
      chk(32'(ref_pin_oe), 32'h1);
      pairs(8'hFF);
      ref_moves(t);
      chk(32'(t), 32'h1);
   endtask
   task pins_and_bits;
      oe_want_n <= 8'h55;
      settle;
      pairs(8'hAA);
      oe_want_n <= 8'hZZ;
      apb(1'b1, `OFS_CTRL, 32'h0F0);
      settle;
      pairs(8'hF0);
      apb(1'b0, `OFS_CTRL, 32'h0);
      chk(rd, 32'h0F0);
      chk({31'h0, er}, 32'h0);
      apb(1'b0, `OFS_PAIR_STATE, 32'h0);
      chk(rd, 32'h0F0);
      apb(1'b0, `OFS_BUS_ADDR, 32'h0);
      chk(rd, 32'(`ADDR_STRAP_1));
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, `OFS_CTRL, 32'h0FF);
      synth_lock <= 1'b0;
      settle;
      pairs(8'h00);
      synth_lock <= 1'b1;
      settle;
      pairs(8'hFF);
   endtask
   task power_down(input logic wake);
      logic t;
      apb(1'b1, `OFS_CTRL, {23'h0, wake, 8'hFF});
      strap_drive <= ~strap_drive; spread_strap_level <= 2'h3; pg_want <= 1'b0;
      settle;
      pairs(8'h00);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk(32'(rd[`ST_PDOWN_BIT]), 32'h1);
      chk(32'(ref_pin_oe), 32'h1);
      ref_moves(t);
      chk(32'(t), 32'(wake));
      if (!wake) chk(32'(ref_pin_out), 32'h0);
      pg_want <= 1'b1;
      settle;
      pairs(8'hFF);
      chk(32'(bus_address), 32'(`ADDR_STRAP_1));
      chk(32'(spread_select), 32'(`SPREAD_QUARTER));
   endtask
   // wake without lock: both deadline flags rise, then clear by writing ones
   task late_flags;
      pg_want <= 1'b0;
      settle;
      synth_lock <= 1'b0; pg_want <= 1'b1;
      repeat (60) @(posedge pclk);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk(32'(rd[`ST_STAB_LATE_BIT]), 32'h1);
      chk(32'(rd[`ST_DRV_LATE_BIT]), 32'h1);
      synth_lock <= 1'b1;
      apb(1'b1, `OFS_STATUS, (32'h1 << `ST_STAB_LATE_BIT) | (32'h1 << `ST_DRV_LATE_BIT));
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk(32'(rd[`ST_STAB_LATE_BIT]), 32'h0);
      chk(32'(rd[`ST_DRV_LATE_BIT]), 32'h0);
   endtask
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; pg_want = 1'b0; oe_want_n = 8'h00; spread_strap_level = 2'h0;
      synth_lock = 1'b1; strap_drive = 1'b0; n_mismatch = 0; compares = 0; cycles = 0;
      start_up(1'b0, 2'h0, `SPREAD_OFF);
      start_up(1'b0, 2'h3, `SPREAD_HALF);
      start_up(1'b1, 2'h1, `SPREAD_QUARTER);
      pins_and_bits;
      power_down(1'b0);
      power_down(1'b1);
      late_flags;
      end_of_test;
   end
endmodule
`default_nettype wire
